// *** rrins_unit.sv ***
/*
   Execution unit for interrupt return, literal return, plain return
   and rotate left through carry.
   Assumes the file register read data for instr[6:0] is valid combinationally
   and that the stack owner pops when stack_pop_q pulses, with stack_top valid.
*/
`timescale 1ns/10ps
module rrins_unit #(
   parameter int PC_W = 15
) (
   // Clock and reset.
   input  wire logic                  mclk,
   input  wire logic                  srst,
   // Instruction issue.
   input  wire logic                  instr_valid,
   input  wire logic [13:0]           instr,
   output logic                       busy_q,
   // Return stack.
   input  wire logic [PC_W-1:0]       stack_top,
   output logic                       stack_pop_q,
   // File register access, bank-relative.
   input  wire logic [7:0]            file_rdata,
   output rrins_pkg::rrins_fwr_t      file_wr_q,
   // Core state.
   output logic [PC_W-1:0]            pc_q,
   output logic [7:0]                 w_q,
   output logic                       carry_q,
   output logic                       global_irq_enable_q
);
   // Two states are enough: a return needs one extra slot and nothing else stalls.
   // A wider state field is kept so that later multi-cycle work can be added cheaply.
   typedef enum logic [1:0] {S_IDLE, S_SECOND} rrins_state_t;
   rrins_state_t state_q;

   logic take;
   logic is_ret_irq, is_ret_plain, is_ret_lit, is_rot;
   logic [8:0] rot_res;

   // Decode only in the idle state; a second-cycle slot accepts nothing.
   // The word offered in that slot is the one the fetch stage brought in behind
   // the return, so dropping it without a sign is the intended flush.
   // Words that match no opcode here are still taken and only advance the PC.
   assign take         = instr_valid && (state_q == S_IDLE);
   assign is_ret_irq   = take && (instr == rrins_pkg::OP_RET_IRQ);
   assign is_ret_plain = take && (instr == rrins_pkg::OP_RET_PLAIN);
   assign is_ret_lit   = take && (instr[rrins_pkg::OPC_HI:rrins_pkg::OPC_LO] ==
                                  rrins_pkg::OP_RET_LIT);
   assign is_rot       = take && (instr[rrins_pkg::OPC_HI:rrins_pkg::OPC_LO] ==
                                  rrins_pkg::OP_ROT_LEFT);
   // Shift left: old carry into bit 0, old MSB out to carry.
   assign rot_res = {file_rdata, carry_q}; // [RQ8]

   // Returns hold the unit for a second cycle, which flushes the fetched word.
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= S_IDLE;
      end else if (is_ret_irq || is_ret_plain || is_ret_lit) begin
         state_q <= S_SECOND; // [RQ3] [RQ6] [RQ7]
      end else begin
         state_q <= S_IDLE;
      end
   end

   // Busy mirrors the second cycle of a return.
   always_ff @(posedge mclk) begin
      if (srst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= is_ret_irq || is_ret_plain || is_ret_lit;
      end
   end

   // Pop pulse and PC reload from the stack top.
   // The stack top is sampled on the same edge that raises the pop pulse, so the
   // stack owner may move its pointer on the following edge without a hazard.
   always_ff @(posedge mclk) begin
      if (srst) begin
         stack_pop_q <= 1'b0;
         pc_q        <= rrins_pkg::PC_RESET[PC_W-1:0];
      end else begin
         stack_pop_q <= is_ret_irq || is_ret_plain || is_ret_lit;
         if (is_ret_irq || is_ret_plain || is_ret_lit) begin
            pc_q <= stack_top; // [RQ1] [RQ5] [RQ7]
         end else if (take) begin
            pc_q <= pc_q + PC_W'(1);
         end
      end
   end

   // Only interrupt return touches the enable; plain return leaves it.
   // Clearing the enable belongs to interrupt entry, which lives outside this unit.
   always_ff @(posedge mclk) begin
      if (srst) begin
         global_irq_enable_q <= 1'b0;
      end else if (is_ret_irq) begin
         global_irq_enable_q <= 1'b1; // [RQ2]
      end
   end

   // Accumulator: literal return or rotate with destination 0.
   always_ff @(posedge mclk) begin
      if (srst) begin
         w_q <= rrins_pkg::W_RESET;
      end else if (is_ret_lit) begin
         w_q <= instr[7:0]; // [RQ4]
      end else if (is_rot && !instr[rrins_pkg::DEST_BIT]) begin
         w_q <= rot_res[7:0]; // [RQ9]
      end
   end

   // Carry changes only on rotate; returns leave every flag alone.
   always_ff @(posedge mclk) begin
      if (srst) begin
         carry_q <= 1'b0;
      end else if (is_rot) begin
         carry_q <= rot_res[8]; // [RQ8] [RQ10]
      end
   end

   // Write back to the file register when destination is 1, in one cycle.
   // Address and data follow every cycle; only the enable qualifies them.
   always_ff @(posedge mclk) begin
      if (srst) begin
         file_wr_q <= '0;
      end else begin
         file_wr_q.en   <= is_rot && instr[rrins_pkg::DEST_BIT]; // [RQ9] [RQ10]
         file_wr_q.addr <= instr[6:0];
         file_wr_q.data <= rot_res[7:0];
      end
   end

   // Checks.
   // A return of any kind is taken in this cycle.
   sequence s_ret_taken;
      is_ret_irq || is_ret_plain || is_ret_lit;
   endsequence

   // The unit is busy for exactly the second cycle and then free again.
   sequence s_busy_then_free;
      busy_q ##1 !busy_q;
   endsequence

   // Nothing is issued in the busy slot: no pulse, no state change.
   sequence s_slot_quiet;
      !stack_pop_q && !file_wr_q.en && $stable(pc_q) && $stable(w_q) &&
      $stable(carry_q) && $stable(global_irq_enable_q);
   endsequence

   a_ret_pops_top: assert property (@(posedge mclk) disable iff (srst)
      (is_ret_irq || is_ret_plain || is_ret_lit) |=> stack_pop_q && pc_q == $past(stack_top)) // [RQ1]
      else $error("Return did not load PC from stack top.");
   a_irq_ret_enable: assert property (@(posedge mclk) disable iff (srst)
      is_ret_irq |=> global_irq_enable_q) // [RQ2]
      else $error("Interrupt return did not set the enable.");
   a_ret_two_cycle: assert property (@(posedge mclk) disable iff (srst)
      s_ret_taken |=> s_busy_then_free) // [RQ3]
      else $error("Return did not take two cycles.");
   a_ret_flags_keep: assert property (@(posedge mclk) disable iff (srst)
      s_ret_taken |=> $stable(carry_q)) // [RQ3]
      else $error("Return changed the carry flag.");
   a_busy_slot_quiet: assert property (@(posedge mclk) disable iff (srst)
      busy_q |=> s_slot_quiet) // [RQ3]
      else $error("Work was done in the busy slot of a return.");
   a_lit_loads_w: assert property (@(posedge mclk) disable iff (srst)
      is_ret_lit |=> w_q == $past(instr[7:0])) // [RQ4]
      else $error("Literal return did not load W.");
   a_lit_two_cycle: assert property (@(posedge mclk) disable iff (srst)
      is_ret_lit |=> busy_q && $stable(carry_q)) // [RQ6]
      else $error("Literal return timing or flags wrong.");
   a_plain_ret_keep: assert property (@(posedge mclk) disable iff (srst)
      is_ret_plain |=> $stable(global_irq_enable_q) && $stable(carry_q) && busy_q) // [RQ7]
      else $error("Plain return changed enable or flags.");
   a_rot_value: assert property (@(posedge mclk) disable iff (srst)
      is_rot |=> carry_q == $past(file_rdata[7]) &&
                 (w_q[0] == $past(carry_q) || file_wr_q.data[0] == $past(carry_q))) // [RQ8]
      else $error("Rotate result wrong.");
   a_rot_dest: assert property (@(posedge mclk) disable iff (srst)
      is_rot |=> file_wr_q.en == $past(instr[rrins_pkg::DEST_BIT])) // [RQ9]
      else $error("Rotate destination wrong.");
   a_rot_one_cycle: assert property (@(posedge mclk) disable iff (srst)
      is_rot |=> !busy_q && $stable(global_irq_enable_q)) // [RQ10]
      else $error("Rotate stalled or touched the enable.");
   a_rot_pc_step: assert property (@(posedge mclk) disable iff (srst)
      is_rot |=> pc_q == $past(pc_q) + PC_W'(1)) // [RQ10]
      else $error("Rotate did not advance the PC by one.");
   a_rot_addr_pass: assert property (@(posedge mclk) disable iff (srst)
      is_rot |=> file_wr_q.addr == $past(instr[6:0])) // [RQ10]
      else $error("Rotate write address wrong.");
   a_rot_keeps_pop: assert property (@(posedge mclk) disable iff (srst)
      is_rot |=> !stack_pop_q) // [RQ10]
      else $error("Rotate popped the stack.");
   // Reset is checked without the disable so that its own effect is seen.
   a_reset_clears: assert property (@(posedge mclk)
      srst |=> pc_q == rrins_pkg::PC_RESET[PC_W-1:0] && w_q == rrins_pkg::W_RESET &&
               !carry_q && !global_irq_enable_q && !stack_pop_q && !file_wr_q.en && !busy_q)
      else $error("Reset did not clear the core state.");
endmodule // rrins_unit

// *** rrins_pkg.sv ***
/*
   Package for the return and rotate execution unit.
   Holds opcode encodings, operand field positions and shared carriers.
   Assumes the fetch stage presents one decoded instruction word at a time.
*/
// Behaviour
// [RQ1] Interrupt return pops the stack and loads the top entry into the PC.
// [RQ2] Interrupt return sets the global interrupt enable, bit 7 of interrupt control.
// [RQ3] Interrupt return is one word, two cycles, and leaves status flags alone.
// [RQ4] Literal return loads its 8-bit literal into W, flags untouched.
// [RQ5] Literal return loads the PC from the popped stack top.
// [RQ6] Literal return is one word and takes two cycles.
// [RQ7] Plain return pops into PC, two cycles, enable and flags untouched.
// [RQ8] Rotate left shifts f left, old carry to bit 0, old MSB to carry.
// [RQ9] Rotate destination bit 0 writes W, 1 writes back to f.
// [RQ10] Rotate takes one cycle, changes only carry, addresses f 0 to 127.
package rrins_pkg;
   // Opcode encodings of the 14-bit instruction word.
   localparam logic [13:0] OP_RET_IRQ  = 14'h0009;
   localparam logic [13:0] OP_RET_PLAIN = 14'h0008;
   localparam logic [5:0]  OP_RET_LIT  = 6'h34;   // Upper six bits, literal below.
   localparam logic [5:0]  OP_ROT_LEFT = 6'h0d;   // Upper six bits, d and f below.
   // Field positions.
   localparam int DEST_BIT   = 7;
   localparam int GIE_BIT    = 7;
   localparam int OPC_HI     = 13;
   localparam int OPC_LO     = 8;
   // Reset values.
   localparam logic [7:0]  W_RESET   = 8'h00;
   localparam logic [14:0] PC_RESET  = 15'h0000;

   // File register write request.
   typedef struct packed {
      logic       en;
      logic [6:0] addr;
      logic [7:0] data;
   } rrins_fwr_t;
endpackage

// *** tb_top.sv ***
/*
   Self-checking bench for the return and rotate execution unit.
   Assumes the unit answers one edge after it takes an instruction.
*/
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {
      logic [13:0] ins;
      logic [14:0] top;
      logic [7:0]  rd;
      logic        pop;
      logic [14:0] pc;
      logic [7:0]  w;
      logic        c;
      logic        global_irq_enable;
      logic        wen;
      logic [7:0]  wd;
   } rrins_row_t;
   logic                  mclk, srst, instr_valid, busy_q, stack_pop_q, carry_q;
   logic                  global_irq_enable_q;
   logic [13:0]           instr;
   logic [14:0]           stack_top, pc_q;
   logic [7:0]            file_rdata, w_q;
   rrins_pkg::rrins_fwr_t file_wr_q;
   int                    n_errors, checks_done;
   rrins_row_t            rows [6];

   rrins_unit #(.PC_W(15)) i_rrins_unit (.mclk(mclk), .srst(srst), .instr_valid(instr_valid),
      .instr(instr), .busy_q(busy_q), .stack_top(stack_top), .stack_pop_q(stack_pop_q),
      .file_rdata(file_rdata), .file_wr_q(file_wr_q), .pc_q(pc_q), .w_q(w_q),
      .carry_q(carry_q), .global_irq_enable_q(global_irq_enable_q));

   // Free-running 25 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // One comparison, counted; a mismatch is reported at once.
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   // Presents one word for one edge, then lets that edge's updates land.
   task automatic issue(input logic [13:0] i, input logic [14:0] t, input logic [7:0] r);
      instr_valid <= 1'b1;
      instr <= i;
      stack_top <= t;
      file_rdata <= r;
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
   endtask

   task automatic end_sim;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Watchdog: the whole run needs well under 100 cycles.
   initial begin
      #100000;
      n_errors++;
      end_sim();
   end

   initial begin
      srst = 1'b1; instr_valid = 1'b0; instr = 14'h0000; stack_top = 15'h0000;
      file_rdata = 8'h00; n_errors = 0; checks_done = 0;
      rows[0] = {14'h0008, 15'h1234, 8'h00, 1'b1, 15'h1234, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00};
      rows[1] = {14'h0d85, 15'h0000, 8'he6, 1'b0, 15'h1235, 8'h00, 1'b1, 1'b0, 1'b1, 8'hcc};
      rows[2] = {14'h0d7f, 15'h0000, 8'h01, 1'b0, 15'h1236, 8'h03, 1'b0, 1'b0, 1'b0, 8'h00};
      rows[3] = {14'h34ff, 15'h7fff, 8'h00, 1'b1, 15'h7fff, 8'hff, 1'b0, 1'b0, 1'b0, 8'h00};
      rows[4] = {14'h0009, 15'h2aaa, 8'h00, 1'b1, 15'h2aaa, 8'hff, 1'b0, 1'b1, 1'b0, 8'h00};
      rows[5] = {14'h3400, 15'h0001, 8'h5a, 1'b1, 15'h0001, 8'h00, 1'b0, 1'b1, 1'b0, 8'h00};
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      // Ordinary cases, each followed by one idle cycle.
      foreach (rows[k]) begin
         issue(rows[k].ins, rows[k].top, rows[k].rd);
         chk(stack_pop_q === rows[k].pop && busy_q === rows[k].pop, "pop");
         chk(pc_q === rows[k].pc, "pc");
         chk(w_q === rows[k].w, "w");
         chk(carry_q === rows[k].c, "carry");
         chk(global_irq_enable_q === rows[k].global_irq_enable, "irq enable");
         chk(file_wr_q.en === rows[k].wen, "write enable");
         if (rows[k].wen) chk(file_wr_q.data === rows[k].wd && file_wr_q.addr === 7'h05, "wr");
         @(posedge mclk);
         #1;
         chk(stack_pop_q === 1'b0 && busy_q === 1'b0 && file_wr_q.en === 1'b0, "pulse");
      end
      // A rotate offered in the busy cycle of a return is dropped.
      issue(14'h0008, 15'h0042, 8'h00);
      issue(14'h0d05, 15'h0000, 8'h80);
      chk(w_q === 8'h00 && carry_q === 1'b0 && pc_q === 15'h0042, "busy");
      chk(global_irq_enable_q === 1'b1, "enable kept");
      // Back-to-back rotates chain the carry.
      issue(14'h0d81, 15'h0000, 8'h80);
      chk(file_wr_q.data === 8'h00 && carry_q === 1'b1 && pc_q === 15'h0043, "rot a");
      issue(14'h0d02, 15'h0000, 8'h00);
      chk(w_q === 8'h01 && carry_q === 1'b0 && file_wr_q.en === 1'b0, "rot b");
      chk(pc_q === 15'h0044 && stack_pop_q === 1'b0, "rot b pc");
      // Reset in mid-run clears the core state.
      srst <= 1'b1;
      @(posedge mclk);
      #1;
      chk(pc_q === 15'h0000 && w_q === 8'h00 && global_irq_enable_q === 1'b0, "reset");
      chk(carry_q === 1'b0 && busy_q === 1'b0 && stack_pop_q === 1'b0, "reset flags");
      srst <= 1'b0;
      // The first edge after release already takes an instruction.
      issue(14'h0009, 15'h0123, 8'h00);
      chk(pc_q === 15'h0123 && stack_pop_q === 1'b1, "after reset pc");
      chk(global_irq_enable_q === 1'b1 && busy_q === 1'b1, "after reset enable");
      end_sim();
   end
endmodule // tb_top
